// >>> include/ebc_map.vh
// Register offsets, field positions and reset values of the bus configuration
`ifndef EBC_MAP_VH
`define EBC_MAP_VH
`define EBC_OFF_CFG0      16'hff0c
`define EBC_OFF_CFG1      16'hff14
`define EBC_OFF_CFG2      16'hff16
`define EBC_OFF_CFG3      16'hff18
`define EBC_OFF_CFG4      16'hff1a
`define EBC_OFF_RSTLATCH  16'hf108
`define EBC_OFF_WIN1      16'hfe18
`define EBC_OFF_WIN2      16'hfe1a
`define EBC_OFF_WIN3      16'hfe1c
`define EBC_OFF_WIN4      16'hfe1e
`define EBC_BIT_WRSEL     15
`define EBC_BIT_RDSEL     14
`define EBC_BIT_RDYPOL    13
`define EBC_BIT_RDYEN     12
`define EBC_BIT_BUSEN     10
`define EBC_BIT_ALELONG   9
`define EBC_BUS_TYPE_HI       7
`define EBC_BUS_TYPE_LO       6
`define EBC_BIT_TRIWAIT   5
`define EBC_BIT_RWDELAY   4
`define EBC_WAIT_HI       3
`define EBC_WAIT_LO       0
`define EBC_CFG_WMASK     16'hf6ff
`define EBC_CFG_RESET     16'h0000
`define EBC_CFG0_EXT_SET  16'h0600
`define EBC_RST_DEFAULT   8'hff
`define EBC_WAIT_MAX      4'hf
`endif

// >>> verilog/ebc_config.v
// External bus configuration registers, reset latch and cycle timing
`timescale 1ns/1ps
`include "ebc_map.vh"

// Overview of operation
// RULE1: Bit 15 set gates chip select with the write strobe.
// RULE2: Bit 14 set gates chip select with the read strobe.
// RULE3: Bit 13 picks ready level; external device drives it to end cycle.
// RULE4: Bit 12 picks ready-ended cycle over programmed wait states.
// RULE5: Bit 10 enables the external bus for that window.
// RULE6: Bit 9 lengthens the address latch pulse.
// RULE7: Bus type field picks 8/16 bit, muxed or demuxed.
// RULE8: Register 0 bus type loads from port 0 bits 6-7 at reset end.
// RULE9: External access pin high gives zero; low sets enable and lengthen.
// RULE10: Bit 5 clear inserts one tristate wait state.
// RULE11: Bit 4 clear delays strobes one half clock after latch falls.
// RULE12: Wait states equal fifteen minus the four-bit cycle field.
// RULE13: Reset latch register is read-only, captured each reset.
// RULE14: Clock select bits captured only on long reset; default FFh. No default is loaded here; bits 7:5 stay unset until the first long reset.
// RULE15: Clock select field gives the CPU clock multiple.
// RULE16: Segment field picks four, none, eight or two address lines.
// RULE17: Chip-select field picks three, two, none or five lines.
// RULE18: Write-mode bit zero makes write pins byte strobes.
// RULE19: Write-mode inverse always mirrors the inverted write-mode bit.
// RULE20: An access uses the config paired with its matching window.
// RULE21: An access matching no enabled window uses config 0.
module ebc_config #(
	parameter WIN_BITS = 8
) (
	input  wire        core_clk,
	input  wire        reset,
	input  wire        clk_en,
	input  wire        long_reset,
	input  wire        external_access_pin,
	input  wire [7:0]  port0_cfg,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [15:0] reg_addr,
	input  wire [15:0] reg_wdata,
	output reg  [15:0] reg_rdata,
	input  wire        acc_req,
	input  wire        acc_write,
	input  wire [23:0] acc_addr,
	input  wire        ready_in,
	output reg         acc_done,
	output reg         acc_external,
	output reg  [2:0]  acc_sel,
	output reg  [1:0]  bus_type,
	output reg         latch_pulse_lengthen,
	output reg         strobe_delay,
	output reg         chip_select_n,
	output reg         strobe_n,
	output wire        write_mode_inverse,
	output wire [2:0]  clock_multiplier_sel,
	output wire [1:0]  segment_line_sel,
	output wire [1:0]  select_line_count
);

	// Bus cycle sequencer states
	localparam ST_IDLE = 2'd0;
	localparam ST_TRI  = 2'd1;
	localparam ST_WAIT = 2'd2;
	localparam ST_DONE = 2'd3;

	reg [15:0] cfg_reg [0:4];
	reg [15:0] win_reg [1:4];
	reg [7:0]  rst_latch_reg;
	reg        in_reset_reg;
	reg [1:0]  state_reg;
	reg [3:0]  wait_reg;
	reg [15:0] act_cfg_reg;
	reg        ready_ok;
	reg [2:0]  hit;
	integer    i;
	// Decode of the pending request and of the register bus
	reg        cs_qual_reg;
	wire [4:1] win_match;
	wire [15:0] req_cfg;
	wire       req_bus_on;
	wire       req_ale_long;
	wire       req_delayed;
	wire       req_qual;
	wire [1:0] req_type;
	wire [3:0] req_wait;
	wire       cycle_end;
	wire [2:0] bus_cfg_idx;
	wire [2:0] bus_win_idx;
	wire       bus_cfg_hit;
	wire       bus_win_hit;
	wire       bus_latch_hit;
	genvar     g;

	// Map register offsets to config slot, 7 when none
	function [2:0] cfg_index;
		input [15:0] a;
		begin
			case (a)
				`EBC_OFF_CFG0: cfg_index = 3'd0;
				`EBC_OFF_CFG1: cfg_index = 3'd1;
				`EBC_OFF_CFG2: cfg_index = 3'd2;
				`EBC_OFF_CFG3: cfg_index = 3'd3;
				`EBC_OFF_CFG4: cfg_index = 3'd4;
				default:       cfg_index = 3'd7;
			endcase
		end
	endfunction

	// Map window register offsets to window slot, 0 when none
	function [2:0] win_index;
		input [15:0] a;
		begin
			case (a)
				`EBC_OFF_WIN1: win_index = 3'd1;
				`EBC_OFF_WIN2: win_index = 3'd2;
				`EBC_OFF_WIN3: win_index = 3'd3;
				`EBC_OFF_WIN4: win_index = 3'd4;
				default:       win_index = 3'd0;
			endcase
		end
	endfunction

	// Register bus decode shared by the write and read paths
	assign bus_cfg_idx   = cfg_index(reg_addr);
	assign bus_win_idx   = win_index(reg_addr);
	assign bus_cfg_hit   = (bus_cfg_idx != 3'd7);
	assign bus_win_hit   = (bus_win_idx != 3'd0);
	assign bus_latch_hit = (reg_addr == `EBC_OFF_RSTLATCH);

	// Reset latch fields decoded for the rest of the chip
	// Only the clock bits depend on the kind of reset
	assign clock_multiplier_sel = rst_latch_reg[7:5];  // RULE15
	assign segment_line_sel     = rst_latch_reg[4:3];  // RULE16
	assign select_line_count    = rst_latch_reg[2:1];  // RULE17
	assign write_mode_inverse   = ~rst_latch_reg[0];   // RULE18 RULE19

	// Register writes and reset-time capture
	// Writes in the cycle that loads register 0 are dropped
	always @(posedge core_clk) begin
		if (reset) begin
			in_reset_reg <= 1'b1;
			for (i = 1; i <= 4; i = i + 1) begin
				cfg_reg[i] <= `EBC_CFG_RESET;
				win_reg[i] <= 16'h0000;
			end
			cfg_reg[0] <= `EBC_CFG_RESET;
			if (clk_en) begin
				// Latch captured during every reset; clock bits on long only
				rst_latch_reg[4:0] <= port0_cfg[4:0];  // RULE13
				if (long_reset)
					rst_latch_reg[7:5] <= port0_cfg[7:5];  // RULE14
			end
		end else if (clk_en) begin
			in_reset_reg <= 1'b0;
			if (in_reset_reg) begin
				// End of reset: register 0 from pin and port
				if (external_access_pin)
					cfg_reg[0] <= `EBC_CFG_RESET;  // RULE9
				else
					cfg_reg[0] <= `EBC_CFG0_EXT_SET |
						{8'h00, port0_cfg[7:6], 6'h00};  // RULE8 RULE9
			end else if (reg_wr) begin
				if (bus_cfg_hit)
					cfg_reg[bus_cfg_idx] <=
						reg_wdata & `EBC_CFG_WMASK;  // RULE7
				if (bus_win_hit)
					win_reg[bus_win_idx] <= reg_wdata;  // RULE20
			end
		end
	end

	// Read mux; latch register is read-only
	always @(posedge core_clk) begin
		if (reset)
			reg_rdata <= 16'h0000;
		else if (clk_en && reg_rd) begin
			if (bus_cfg_hit)
				reg_rdata <= cfg_reg[bus_cfg_idx];
			else if (bus_win_hit)
				reg_rdata <= win_reg[bus_win_idx];
			else if (bus_latch_hit)
				reg_rdata <= {8'h00, rst_latch_reg};  // RULE13
			else
				reg_rdata <= 16'h0000;
		end
	end

	// Per-window match: bus enabled and upper address byte equal to base
	// A window whose bus is off never claims an access, whatever its base
	generate
		for (g = 1; g <= 4; g = g + 1) begin : g_win
			assign win_match[g] = cfg_reg[g][`EBC_BIT_BUSEN] &&
				(acc_addr[23 -: WIN_BITS] ==
				 win_reg[g][WIN_BITS-1:0]);  // RULE5 RULE20
		end
	endgenerate

	// Lowest-numbered matching window wins; no match falls back to 0
	always @* begin
		hit = 3'd0;  // RULE21
		if (win_match[4])
			hit = 3'd4;  // RULE20
		if (win_match[3])
			hit = 3'd3;  // RULE20
		if (win_match[2])
			hit = 3'd2;  // RULE20
		if (win_match[1])
			hit = 3'd1;  // RULE20
	end

	// Configuration and fields seen by the pending request
	assign req_cfg      = cfg_reg[hit];  // RULE20
	assign req_bus_on   = req_cfg[`EBC_BIT_BUSEN];  // RULE5
	assign req_ale_long = req_cfg[`EBC_BIT_ALELONG];  // RULE6
	assign req_delayed  = ~req_cfg[`EBC_BIT_RWDELAY];  // RULE11
	assign req_type     = req_cfg[`EBC_BUS_TYPE_HI:`EBC_BUS_TYPE_LO];  // RULE7
	assign req_wait     = `EBC_WAIT_MAX -
		req_cfg[`EBC_WAIT_HI:`EBC_WAIT_LO];  // RULE12

	// Select qualified by the strobe of this access direction only
	assign req_qual = acc_write ? req_cfg[`EBC_BIT_WRSEL] :
		req_cfg[`EBC_BIT_RDSEL];  // RULE1 RULE2

	// Bus cycle ends on ready or on the programmed wait count
	// With ready enabled a silent device holds the bus; no timeout
	assign cycle_end = act_cfg_reg[`EBC_BIT_RDYEN] ? ready_ok :
		(wait_reg == 4'h0);  // RULE4

	// Ready level test per selected polarity
	// Polarity comes from the snapshot, not the live register
	always @* begin
		ready_ok = (ready_in == act_cfg_reg[`EBC_BIT_RDYPOL]);  // RULE3
	end

	// Bus cycle sequencer
	// Timing is snapshotted at the request, so a register write
	// during a cycle in flight only affects the next access
	always @(posedge core_clk) begin
		if (reset) begin
			state_reg            <= ST_IDLE;
			wait_reg             <= 4'h0;
			act_cfg_reg          <= 16'h0000;
			acc_done             <= 1'b0;
			acc_external         <= 1'b0;
			acc_sel              <= 3'd0;
			bus_type             <= 2'b00;
			latch_pulse_lengthen <= 1'b0;
			strobe_delay         <= 1'b0;
			chip_select_n        <= 1'b1;
			strobe_n             <= 1'b1;
			cs_qual_reg          <= 1'b0;
		end else if (clk_en) begin
			acc_done <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					strobe_n      <= 1'b1;
					chip_select_n <= 1'b1;
					if (acc_req) begin
						// Requests outside idle are dropped, not queued
						// Snapshot the matched configuration
						act_cfg_reg  <= req_cfg;  // RULE20
						acc_sel      <= hit;  // RULE21
						acc_external <= req_bus_on;  // RULE5
						bus_type     <= req_type;  // RULE7
						latch_pulse_lengthen <= req_ale_long;  // RULE6
						strobe_delay <= req_delayed;  // RULE11
						wait_reg     <= req_wait;  // RULE12
						cs_qual_reg  <= req_qual;  // RULE1 RULE2
						if (!req_bus_on) begin
							// Disabled bus: no strobe, finish at once
							acc_done  <= 1'b1;  // RULE5
							state_reg <= ST_IDLE;
						end else begin
							// Select goes active together with the strobe
							strobe_n      <= 1'b0;
							chip_select_n <= 1'b0;  // RULE1 RULE2
							state_reg     <= ST_WAIT;
						end
					end
				end
				ST_WAIT: begin
					// Strobe held until the cycle ends
					if (cycle_end) begin  // RULE3 RULE4
						strobe_n <= 1'b1;
						// Qualified select drops with its strobe
						if (cs_qual_reg)
							chip_select_n <= 1'b1;  // RULE1 RULE2
						state_reg <= act_cfg_reg[`EBC_BIT_TRIWAIT] ?
							ST_DONE : ST_TRI;  // RULE10
					end else if (wait_reg != 4'h0)
						wait_reg <= wait_reg - 4'h1;  // RULE12
				end
				ST_TRI: begin
					// Extra cycle for the bus to float back
					state_reg <= ST_DONE;  // RULE10
				end
				ST_DONE: begin
					// Pulse done; an unqualified select ends here
					chip_select_n <= 1'b1;
					acc_done      <= 1'b1;
					state_reg     <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

endmodule

// >>> tb/ebc_chk.sv
// Port-level assertions for the bus configuration block
`timescale 1ns/1ps
module ebc_chk (
	input logic        core_clk,
	input logic        reset,
	input logic        reg_rd,
	input logic [15:0] reg_addr,
	input logic [15:0] reg_rdata,
	input logic        acc_done,
	input logic        acc_external,
	input logic        chip_select_n,
	input logic        strobe_n,
	input logic        write_mode_inverse,
	input logic [2:0]  clock_multiplier_sel,
	input logic [1:0]  segment_line_sel,
	input logic [1:0]  select_line_count
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// Reads of the reset latch and of the config registers
	wire rd_l = reg_rd && reg_addr == 16'hf108;
	wire rd_c = reg_rd && reg_addr inside {16'hff0c, 16'hff14, 16'hff16,
		16'hff18, 16'hff1a};
	a_mode_inverse: assert property (rd_l |=>
		reg_rdata[0] != write_mode_inverse) else $error("mode inverse");
	a_latch_fields: assert property (rd_l |=>
		reg_rdata[7:1] == {clock_multiplier_sel, segment_line_sel,
		select_line_count}) else $error("latch fields");
	a_latch_upper: assert property (rd_l |=>
		reg_rdata[15:8] == 8'h00) else $error("latch upper");
	a_cfg_reserved: assert property (rd_c |=>
		!reg_rdata[11] && !reg_rdata[8]) else $error("reserved bits");
	a_done_pulse: assert property (acc_done |=> !acc_done)
		else $error("done too long");
	a_select_strobe: assert property (!strobe_n |-> !chip_select_n)
		else $error("select off");
	a_done_released: assert property (acc_done |-> strobe_n)
		else $error("strobe held");
	a_tristate_gap: assert property ($rose(strobe_n) |-> ##[0:2] acc_done)
		else $error("late done");
	a_bus_off: assert property (acc_done && !acc_external |->
		strobe_n && $past(strobe_n)) else $error("strobe off bus");
endmodule
bind ebc_config ebc_chk u_chk (.core_clk(core_clk), .reset(reset),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
	.acc_done(acc_done), .acc_external(acc_external),
	.chip_select_n(chip_select_n), .strobe_n(strobe_n),
	.write_mode_inverse(write_mode_inverse),
	.clock_multiplier_sel(clock_multiplier_sel),
	.segment_line_sel(segment_line_sel),
	.select_line_count(select_line_count));

// >>> tb/ebc_mem_model.sv
// External device model answering the ready line after a set delay
`timescale 1ns/1ps
module ebc_mem_model (
	input  wire       core_clk,
	input  wire       strobe_n,
	input  wire       pol,
	input  wire [3:0] dly,
	output wire       ready_in
);
	reg [3:0] cnt_reg;
	// Count cycles of an active strobe
	always @(posedge core_clk) begin
		if (strobe_n)
			cnt_reg <= 4'h0;
		else if (cnt_reg != 4'hf)
			cnt_reg <= cnt_reg + 4'h1;
	end
	// Active level after the delay, inverse level otherwise
	assign ready_in = (!strobe_n && cnt_reg >= dly) ? pol : !pol;
endmodule

// >>> tb/tb.sv
// Self-checking bench for the external bus configuration block
`timescale 1ns/1ps
`include "ebc_map.vh"
module tb;
	reg         core_clk, reset, long_reset, ea, reg_wr, reg_rd;
	reg         acc_req, acc_write, pol;
	reg  [7:0]  p0;
	reg  [3:0]  dly;
	reg  [15:0] reg_addr, reg_wdata, c;
	reg  [23:0] acc_addr;
	wire [15:0] rdata;
	wire        done, ext, lng, sdl, cs_n, st_n, wmi, rdy;
	wire [2:0]  sel, cms;
	wire [1:0]  bus_type, sls, slc;
	integer     errors, total_checks, cyc, n, i, d;
	ebc_config DUT (.core_clk(core_clk), .reset(reset), .clk_en(1'b1),
		.long_reset(long_reset), .external_access_pin(ea), .port0_cfg(p0),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(rdata), .acc_req(acc_req),
		.acc_write(acc_write), .acc_addr(acc_addr), .ready_in(rdy),
		.acc_done(done), .acc_external(ext), .acc_sel(sel),
		.bus_type(bus_type), .latch_pulse_lengthen(lng), .strobe_delay(sdl),
		.chip_select_n(cs_n), .strobe_n(st_n), .write_mode_inverse(wmi),
		.clock_multiplier_sel(cms), .segment_line_sel(sls),
		.select_line_count(slc));
	ebc_mem_model u_mem (.core_clk(core_clk), .strobe_n(st_n), .pol(pol),
		.dly(dly), .ready_in(rdy));
	// 100 MHz clock
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	// Hang guard
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			errors = errors + 1;
			wrap_up;
		end
	end
	task wrap_up; begin
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end endtask
	task chk(input [23:0] s, input [23:0] e); begin
		total_checks = total_checks + 1;
		if (s !== e) begin
			errors = errors + 1;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	end endtask
	task wr(input [15:0] a, input [15:0] v); begin
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1;
		@(negedge core_clk);
		reg_wr = 0;
		@(negedge core_clk);
	end endtask
	task rd(input [15:0] a, input [15:0] e); begin
		reg_addr = a;
		reg_rd = 1;
		@(negedge core_clk);
		reg_rd = 0;
		chk(rdata, e);
		@(negedge core_clk);
	end endtask
	task acc(input w, input [23:0] a); begin
		acc_req = 1;
		acc_write = w;
		acc_addr = a;
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			@(negedge core_clk);
			acc_req = 0;
			n = n + 1;
		end
		@(negedge core_clk);
	end endtask
	task do_reset(input e, input lr, input [7:0] p); begin
		reset = 1;
		ea = e;
		long_reset = lr;
		p0 = p;
		repeat (12) @(negedge core_clk);
		reset = 0;
		repeat (2) @(negedge core_clk);
	end endtask
	// Main sequence
	initial begin
		errors = 0;
		total_checks = 0;
		cyc = 0;
		{reg_wr, reg_rd, acc_req, acc_write, pol} = 0;
		{reg_addr, reg_wdata, acc_addr} = 0;
		dly = 4'h1;
		do_reset(1'b0, 1'b1, 8'h5a);
		rd(`EBC_OFF_CFG0, 16'h0640);
		wr(`EBC_OFF_RSTLATCH, 16'h0000);
		rd(`EBC_OFF_RSTLATCH, 16'h005a);
		chk({wmi, cms, sls, slc}, 8'had);
		for (i = 0; i < 4; i = i + 1) begin
			c = {i[1:0], 4'b0001, i[0], 1'b0, i[1:0], i[0], i[1], 4'h0};
			c[3:0] = i * 5;
			wr(`EBC_OFF_CFG0, c);
			acc(i[0], 24'h00_0100);
			chk(n - 1, 17 - i * 5 + (i[0] ? 0 : 1));
			chk({bus_type, lng, sdl}, {i[1:0], i[0], !i[1]});
			chk({sel, ext}, 4'h1);
		end
		for (i = 0; i < 2; i = i + 1) begin
			wr(`EBC_OFF_CFG0, {2'b00, i[0], 13'h1420});
			pol = i;
			dly = 4'h1;
			acc(1'b0, 24'h00_0000);
			d = n;
			dly = 4'h4;
			acc(1'b0, 24'h00_0000);
			chk(n - d, 3);
		end
		wr(`EBC_OFF_WIN1, 16'h0012);
		wr(`EBC_OFF_CFG1, 16'h062a);
		acc(1'b1, 24'h12_0000);
		chk({n - 1, sel, ext}, {5'd7, 3'd1, 1'b1});
		wr(`EBC_OFF_CFG2, 16'hffff);
		rd(`EBC_OFF_CFG2, 16'hf6ff);
		wr(`EBC_OFF_WIN2, 16'h0034);
		wr(`EBC_OFF_CFG2, 16'h0000);
		wr(`EBC_OFF_CFG0, 16'h0000);
		acc(1'b1, 24'h34_5678);
		chk({n, ext}, 2);
		do_reset(1'b1, 1'b0, 8'h00);
		rd(`EBC_OFF_CFG0, 16'h0000);
		rd(`EBC_OFF_RSTLATCH, 16'h0040);
		wrap_up;
	end
endmodule
